// File: design/cle_cell.sv
// Configurable logic cell with table, chains, packed register and an APB register file.
`timescale 1ns/1ps
module cle_cell #(
   parameter int BUS_N = cle_pkg::CLE_BUS_N
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Asynchronous reset, low active
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [cle_pkg::CLE_ADDR_W-1:0] paddr, // APB byte address
   input wire logic [cle_pkg::CLE_DATA_W-1:0] pwdata, // APB write data
   output logic [cle_pkg::CLE_DATA_W-1:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic data_a, // First data input
   input wire logic data_b, // Second data input
   input wire logic async_load_data_input, // Third data input, load data
   input wire logic direct_register_input, // Fourth data input
   input wire logic cell_clock_enable, // Register clock enable
   input wire logic carry_in, // Carry from previous cell
   input wire logic cascade_in, // Cascade from previous cell
   input wire logic block_control_first_n, // First group control line
   input wire logic block_control_second_n, // Second group control line
   input wire logic chip_reset_n, // Chip-wide reset
   input wire logic [BUS_N-1:0] bus_drive_data, // Emulated bus values
   input wire logic [BUS_N-1:0] bus_drive_en, // Emulated bus enables
   output logic local_out, // Output to local routing
   output logic global_out, // Output to global routing
   output logic carry_out, // Carry to next cell
   output logic cascade_out, // Cascade to next cell
   output logic bus_out // Resolved emulated bus
);
   import cle_pkg::*;

   logic [CLE_CFG_W-1:0] cfg_q;
   logic [CLE_LUT_W-1:0] lut_q;
   logic run_q;
   logic raw_q;
   logic raw_d;
   logic local_q;
   logic global_q;
   logic carry_q;
   logic casc_q;
   logic bus_q;
   logic [CLE_DATA_W-1:0] prdata_q;
   logic [CLE_DATA_W-1:0] rd_d;
   logic pready_q;
   logic pslverr_q;
   logic err_d;
   logic acc;
   logic wr;
   logic [CLE_OP_W-1:0] op;
   logic [CLE_AC_W-1:0] ac;
   logic ctl1;
   logic ctl2;
   logic inv;
   logic q_eff;
   logic in3;
   logic [3:0] idx4;
   logic [2:0] idx_ar;
   logic [2:0] idx_cn;
   logic lut4_out;
   logic sum;
   logic acarry;
   logic third;
   logic cnt_next;
   logic cnt_carry;
   logic cnt_sel;
   logic comb_out;
   logic reg_in;
   logic cout_d;
   logic casc_d;
   logic g_rst;
   logic a_clr;
   logic a_ld;
   logic reg_next;
   logic bus_val;

   function automatic logic lut3(input logic [CLE_HALF_W-1:0] m, input logic [2:0] i);
      return m[i];
   endfunction

   assign op = cfg_q[CLE_F_OP +: CLE_OP_W];
   assign ac = cfg_q[CLE_F_AC +: CLE_AC_W];

   // Control lines are active low, so an unused line tied high never acts.
   assign ctl1 = ~block_control_first_n;
   assign ctl2 = ~block_control_second_n;

   // Preset built from the clear path keeps the stored bit inverted.
   assign inv = (ac == CLE_AC_LDPRE) | ((ac == CLE_AC_PRESET) & cfg_q[CLE_F_PINV]);
   assign q_eff = raw_q ^ inv;

   // Normal mode table inputs.
   assign in3 = cfg_q[CLE_F_INSEL] ? carry_in : async_load_data_input;
   assign idx4 = {direct_register_input, in3, data_b, data_a};
   assign lut4_out = lut_q[idx4];

   // Arithmetic mode: the table splits into sum and carry halves.
   assign idx_ar = {carry_in, data_b, data_a};
   assign sum = lut3(lut_q[CLE_HALF_W-1:0], idx_ar);
   assign acarry = lut3(lut_q[CLE_LUT_W-1:CLE_HALF_W], idx_ar);

   // Counter modes: direction comes from the cascade input only in up/down mode.
   assign third = (op == CLE_OP_UPDOWN) ? cascade_in : 1'b1;
   assign idx_cn = {third, carry_in, q_eff};
   assign cnt_next = lut3(lut_q[CLE_HALF_W-1:0], idx_cn);
   assign cnt_carry = lut3(lut_q[CLE_LUT_W-1:CLE_HALF_W], idx_cn);
   assign cnt_sel = direct_register_input ? data_b : (data_a ? cnt_next : q_eff);

   always_comb begin
      comb_out = lut4_out;
      reg_in = lut4_out;
      cout_d = carry_in;
      unique case (op)
         CLE_OP_NORMAL: begin
            comb_out = lut4_out;
            reg_in = cfg_q[CLE_F_PACK] ? direct_register_input : lut4_out;
            cout_d = carry_in;
         end
         CLE_OP_ARITH: begin
            comb_out = sum;
            reg_in = sum;
            cout_d = acarry;
         end
         CLE_OP_UPDOWN: begin
            comb_out = cnt_next;
            reg_in = cnt_sel;
            cout_d = cnt_carry;
         end
         CLE_OP_CLRCNT: begin
            comb_out = cnt_next;
            reg_in = cnt_sel & cascade_in;
            cout_d = cnt_carry;
         end
      endcase
   end

   // The cascade input is a counter control in the counter modes, so it is only merged in the other two.
   always_comb begin
      casc_d = comb_out;
      if (cfg_q[CLE_F_CASC] && (op == CLE_OP_NORMAL || op == CLE_OP_ARITH)) begin
         casc_d = comb_out & cascade_in;
      end
   end

   always_comb begin
      a_clr = 1'b0;
      a_ld = 1'b0;
      unique case (ac)
         CLE_AC_CLEAR: begin
            a_clr = ctl1 | ctl2;
         end
         CLE_AC_PRESET: begin
            if (cfg_q[CLE_F_PINV]) begin
               a_clr = ctl1;
            end else begin
               a_ld = ctl1;
            end
         end
         CLE_AC_CLRPRE, CLE_AC_LDCLR, CLE_AC_LDPRE: begin
            a_clr = ctl2;
            a_ld = ctl1;
         end
         CLE_AC_LOAD: begin
            a_ld = ctl1;
         end
         default: begin
            a_clr = 1'b0;
            a_ld = 1'b0;
         end
      endcase
   end

   assign g_rst = cfg_q[CLE_F_GREN] & ~chip_reset_n;

   // The asynchronous controls act on the next edge; clear beats load, and both beat the clock enable.
   always_comb begin
      raw_d = raw_q;
      if (g_rst) begin
         raw_d = cfg_q[CLE_F_GRPRE] ^ inv;
      end else if (a_clr) begin
         raw_d = 1'b0;
      end else if (a_ld) begin
         raw_d = async_load_data_input ^ inv;
      end else if (run_q && cell_clock_enable) begin
         raw_d = reg_in ^ inv;
      end
   end

   assign reg_next = raw_d ^ inv;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_q <= 1'b0;
      end else begin
         raw_q <= raw_d;
      end
   end

   cle_tribus #(.N(BUS_N)) u_bus (
      .drv_data(bus_drive_data),
      .drv_en(bus_drive_en),
      .bus_level(bus_val)
   );

   // Registered outputs delay table paths by one cycle; register paths show the same value as the cell register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         local_q <= 1'b0;
         global_q <= 1'b0;
         carry_q <= 1'b0;
         casc_q <= 1'b0;
         bus_q <= 1'b0;
      end else begin
         local_q <= cfg_q[CLE_F_LSEL] ? reg_next : comb_out;
         global_q <= cfg_q[CLE_F_GSEL] ? reg_next : comb_out;
         carry_q <= cout_d;
         casc_q <= casc_d;
         bus_q <= bus_val;
      end
   end

   assign local_out = local_q;
   assign global_out = global_q;
   assign carry_out = carry_q;
   assign cascade_out = casc_q;
   assign bus_out = bus_q;

   // APB slave with one wait state so that every answer comes from a flip-flop.
   assign acc = psel & penable & ~pready_q;
   assign wr = psel & penable & pready_q & pwrite & ~pslverr_q;

   always_comb begin
      rd_d = '0;
      err_d = 1'b0;
      unique case (paddr)
         CLE_OFF_CFG: begin
            rd_d[CLE_CFG_W-1:0] = cfg_q;
            err_d = pwrite & run_q;
         end
         CLE_OFF_LUT: begin
            rd_d[CLE_LUT_W-1:0] = lut_q;
            err_d = pwrite & run_q;
         end
         CLE_OFF_CTRL: begin
            rd_d[CLE_F_RUN] = run_q;
         end
         CLE_OFF_STAT: begin
            rd_d[CLE_S_Q] = q_eff;
            rd_d[CLE_S_COMB] = comb_out;
            rd_d[CLE_S_COUT] = carry_q;
            rd_d[CLE_S_CASC] = casc_q;
            rd_d[CLE_S_BUS] = bus_q;
            rd_d[CLE_S_RUN] = run_q;
            err_d = pwrite;
         end
         default: begin
            err_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc ? err_d : 1'b0;
         if (acc) begin
            prdata_q <= pwrite ? '0 : rd_d;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // Table and mode changes are refused while the cell runs, so a running cell never sees them move.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= CLE_CFG_RST;
      end else if (wr && paddr == CLE_OFF_CFG) begin
         cfg_q <= pwdata[CLE_CFG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lut_q <= CLE_LUT_RST;
      end else if (wr && paddr == CLE_OFF_LUT) begin
         lut_q <= pwdata[CLE_LUT_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
      end else if (wr && paddr == CLE_OFF_CTRL) begin
         run_q <= pwdata[CLE_F_RUN];
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_grst;
      run_q && g_rst |=> q_eff == $past(cfg_q[CLE_F_GRPRE]);
   endproperty
   a_grst: assert property (p_grst) else $error("Chip reset did not set the register.");

   property p_clear;
      run_q && ac == CLE_AC_CLEAR && (ctl1 || ctl2) && !g_rst |=> !q_eff;
   endproperty
   a_clear: assert property (p_clear) else $error("Clear mode left the register set.");

   property p_clrpre;
      run_q && ac == CLE_AC_CLRPRE && ctl1 && !ctl2 && async_load_data_input && !g_rst |=> q_eff;
   endproperty
   a_clrpre: assert property (p_clrpre) else $error("Preset by load failed.");

   property p_ldpre;
      run_q && ac == CLE_AC_LDPRE && ctl2 && !g_rst |=> q_eff;
   endproperty
   a_ldpre: assert property (p_ldpre) else $error("Inverted clear did not preset.");

   property p_load;
      run_q && ac == CLE_AC_LOAD && ctl1 && !g_rst |=> q_eff == $past(async_load_data_input);
   endproperty
   a_load: assert property (p_load) else $error("Asynchronous load took the wrong value.");

   property p_pack;
      run_q && op == CLE_OP_NORMAL && cfg_q[CLE_F_PACK] && cell_clock_enable && !a_clr && !a_ld && !g_rst
         |=> q_eff == $past(direct_register_input);
   endproperty
   a_pack: assert property (p_pack) else $error("Packed register missed the direct input.");

   property p_hold;
      run_q && !cell_clock_enable && !a_clr && !a_ld && !g_rst |=> $stable(q_eff);
   endproperty
   a_hold: assert property (p_hold) else $error("Register moved without clock enable.");

   property p_sclr;
      run_q && op == CLE_OP_CLRCNT && !cascade_in && cell_clock_enable && !a_clr && !a_ld && !g_rst |=> !q_eff;
   endproperty
   a_sclr: assert property (p_sclr) else $error("Synchronous clear did not clear the count.");

   property p_bus;
      $countones(bus_drive_en) != 1 |=> bus_q == ($past(bus_drive_en) == '0);
   endproperty
   a_bus: assert property (p_bus) else $error("Emulated bus resolved wrongly.");

   property p_sum;
      run_q && op == CLE_OP_ARITH && !cfg_q[CLE_F_LSEL] |=> local_q == $past(sum);
   endproperty
   a_sum: assert property (p_sum) else $error("Local output lost the sum.");

   property p_gsel;
      run_q && cfg_q[CLE_F_GSEL] |=> global_q == q_eff;
   endproperty
   a_gsel: assert property (p_gsel) else $error("Global output not following the register.");

   property p_lock;
      run_q && psel && penable && pwrite && paddr == CLE_OFF_CFG |=> $stable(cfg_q);
   endproperty
   a_lock: assert property (p_lock) else $error("Configuration changed while running.");

   property p_ready;
      psel && penable && !pready_q |=> pready_q ##1 !pready_q;
   endproperty
   a_ready: assert property (p_ready) else $error("APB answer not given after one wait state.");
endmodule // cle_cell

// File: design/cle_pkg.sv
// Package: constants, field layout and modes of the configurable logic cell.
package cle_pkg;
   localparam int CLE_ADDR_W = 12;
   localparam int CLE_DATA_W = 32;
   localparam logic [11:0] CLE_OFF_CFG = 12'h000;
   localparam logic [11:0] CLE_OFF_LUT = 12'h004;
   localparam logic [11:0] CLE_OFF_CTRL = 12'h008;
   localparam logic [11:0] CLE_OFF_STAT = 12'h00C;
   // Operating mode codes.
   localparam int CLE_OP_W = 2;
   localparam logic [1:0] CLE_OP_NORMAL = 2'h0;
   localparam logic [1:0] CLE_OP_ARITH = 2'h1;
   localparam logic [1:0] CLE_OP_UPDOWN = 2'h2;
   localparam logic [1:0] CLE_OP_CLRCNT = 2'h3;
   // Asynchronous control mode codes; 6 and 7 give no control at all.
   localparam int CLE_AC_W = 3;
   localparam logic [2:0] CLE_AC_CLEAR = 3'h0;
   localparam logic [2:0] CLE_AC_PRESET = 3'h1;
   localparam logic [2:0] CLE_AC_CLRPRE = 3'h2;
   localparam logic [2:0] CLE_AC_LDCLR = 3'h3;
   localparam logic [2:0] CLE_AC_LDPRE = 3'h4;
   localparam logic [2:0] CLE_AC_LOAD = 3'h5;
   // Configuration word fields.
   localparam int CLE_F_OP = 0;
   localparam int CLE_F_AC = 2;
   localparam int CLE_F_PACK = 5;
   localparam int CLE_F_INSEL = 6;
   localparam int CLE_F_CASC = 7;
   localparam int CLE_F_LSEL = 8;
   localparam int CLE_F_GSEL = 9;
   localparam int CLE_F_PINV = 10;
   localparam int CLE_F_GREN = 11;
   localparam int CLE_F_GRPRE = 12;
   localparam int CLE_CFG_W = 13;
   localparam logic [12:0] CLE_CFG_RST = 13'h0000;
   // Table mask: low half is the first three-input table, high half the second.
   localparam int CLE_LUT_W = 16;
   localparam int CLE_HALF_W = 8;
   localparam logic [15:0] CLE_LUT_RST = 16'h0000;
   // Control and status fields.
   localparam int CLE_F_RUN = 0;
   localparam int CLE_S_Q = 0;
   localparam int CLE_S_COMB = 1;
   localparam int CLE_S_COUT = 2;
   localparam int CLE_S_CASC = 3;
   localparam int CLE_S_BUS = 4;
   localparam int CLE_S_RUN = 5;
   // Emulated bus.
   localparam int CLE_BUS_N = 4;
   localparam logic CLE_BUS_IDLE = 1'b1;
   localparam logic CLE_BUS_FIGHT = 1'b0;
endpackage

// File: design/cle_tribus.sv
// Emulated internal three-state bus built as a multiplexer.
`timescale 1ns/1ps
module cle_tribus #(
   parameter int N = cle_pkg::CLE_BUS_N
) (
   input wire logic [N-1:0] drv_data, // Driver values
   input wire logic [N-1:0] drv_en, // Driver enables, high active
   output logic bus_level // Resolved bus value
);
   import cle_pkg::*;

   logic seen;
   logic multi;
   logic pick;

   // A real floating or contended wire is never produced; the selector gives a defined level instead.
   always_comb begin
      seen = 1'b0;
      multi = 1'b0;
      pick = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (drv_en[i]) begin
            multi = multi | seen;
            seen = 1'b1;
            pick = drv_data[i];
         end
      end
      if (multi) begin
         bus_level = CLE_BUS_FIGHT;
      end else if (!seen) begin
         bus_level = CLE_BUS_IDLE;
      end else begin
         bus_level = pick;
      end
   end
endmodule // cle_tribus

// File: dv/cle_neighbour.sv
// Model of the neighbouring cell that drives the carry and cascade chains.
`timescale 1ns/1ps
module cle_neighbour (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, low active
   input wire logic want_carry, // Carry value to present
   input wire logic want_casc, // Cascade value to present
   output logic carry_q, // Carry into the cell under test
   output logic casc_q // Cascade into the cell under test
);
   // A real neighbour drives its chain outputs from registers, so they move only just after an edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carry_q <= 1'b0;
         casc_q <= 1'b1;
      end else begin
         carry_q <= want_carry;
         casc_q <= want_casc;
      end
   end
endmodule // cle_neighbour

// File: dv/testbench.sv
// Self-checking bench for the configurable logic cell.
`timescale 1ns/1ps
module testbench;
   import cle_pkg::*;
   typedef struct packed {logic e; logic [31:0] d; logic [31:0] m;} cle_exp_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, cv;
   logic d_a, d_b, d_3, d_4, ce, w_carry, w_casc, carry_in, cascade_in, ctl1_n, ctl2_n, grst_n;
   logic [3:0] bd, be;
   logic local_out, global_out, carry_out, cascade_out, bus_out, q, c, e3, cy;
   logic [15:0] lut;
   cle_exp_t exp_q[$];
   cle_exp_t mon_x;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [1:0] eb[6] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0};
   logic [1:0] ec[6] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h3};

   cle_neighbour cle_neighbour_inst (.pclk(pclk), .presetn(presetn), .want_carry(w_carry), .want_casc(w_casc),
      .carry_q(carry_in), .casc_q(cascade_in));
   cle_cell cle_cell_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_a(d_a),
      .data_b(d_b), .async_load_data_input(d_3), .direct_register_input(d_4), .cell_clock_enable(ce),
      .carry_in(carry_in), .cascade_in(cascade_in), .block_control_first_n(ctl1_n),
      .block_control_second_n(ctl2_n), .chip_reset_n(grst_n), .bus_drive_data(bd), .bus_drive_en(be),
      .local_out(local_out), .global_out(global_out), .carry_out(carry_out), .cascade_out(cascade_out),
      .bus_out(bus_out));

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, want);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Reads carry the expected data in d; writes pass a zero mask so only the error answer is judged.
   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
         input logic e);
      exp_q.push_back(cle_exp_t'({e, d, m}));
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      tick(1);
      penable <= 1'b1;
      // No answer time is assumed here; a slave that never answers is caught by the watchdog.
      do begin
         tick(1);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      tick(1);
   endtask
   // Configuration is only accepted while the clock path is stopped, so stop, load, then restart.
   task automatic cfg(input logic [31:0] v, input logic [31:0] l);
      acc(1'b1, CLE_OFF_CTRL, 32'h0000_0000, 32'h0000_0000, 1'b0);
      acc(1'b1, CLE_OFF_LUT, l, 32'h0000_0000, 1'b0);
      acc(1'b1, CLE_OFF_CFG, v, 32'h0000_0000, 1'b0);
      acc(1'b1, CLE_OFF_CTRL, 32'h0000_0001, 32'h0000_0000, 1'b0);
      cv = v;
   endtask
   task automatic stat(input logic [5:0] want, input logic [5:0] m);
      acc(1'b0, CLE_OFF_STAT, 32'(want), 32'(m), 1'b0);
   endtask
   function automatic logic [31:0] cw(input logic [1:0] op, input logic [2:0] ac, input logic [7:0] f);
      return 32'(op) | (32'(ac) << CLE_F_AC) | (32'(f) << CLE_F_PACK);
   endfunction
   // The register is first primed to the opposite of the expected value (high for the hold check, e of 3) so a stuck register shows.
   task automatic step(input logic l1, input logic l2, input logic v3, input logic g, input logic [1:0] e);
      if (e != 2'h2) begin
         d_4 <= (e == 2'h3) ? 1'b1 : !e[0];
         ce <= 1'b1;
         tick(1);
         ce <= 1'b0;
         d_3 <= v3;
         ctl1_n <= !l1;
         ctl2_n <= !l2;
         grst_n <= !g;
         tick(2);
         stat({5'h00, (e == 2'h3) ? 1'b1 : e[0]}, 6'h01);
         ctl1_n <= 1'b1;
         ctl2_n <= 1'b1;
         grst_n <= 1'b1;
         tick(1);
      end
   endtask

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      #1_500_000;
      n_mismatch++;
      print_verdict();
   end
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
         mon_x = exp_q.pop_front();
         check(32'(pslverr), 32'(mon_x.e));
         check(prdata & mon_x.m, mon_x.d & mon_x.m);
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {d_a, d_b, d_3, d_4, ce, w_carry, w_casc, bd, be} = '0;
      {ctl1_n, ctl2_n, grst_n} = 3'h7;
      presetn = 1'b0;
      void'($urandom(32'h19e7));
      tick(10);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         if (i != 3) acc(1'b0, 12'(4 * i), 32'h0000_0000, 32'hFFFF_FFFF, i == 4);
      end
      for (int k = 0; k < 4; k++) begin
         lut = 16'($urandom());
         cfg(cw(CLE_OP_NORMAL, 3'h6, 8'h11 | 8'(k << 1)), 32'(lut));
         ce <= 1'b1;
         for (int j = 0; j < 6; j++) begin
            {d_a, d_b, d_3, d_4, w_carry, w_casc} <= 6'($urandom());
            tick(3);
            c = lut[{d_4, k[0] ? carry_in : d_3, d_b, d_a}];
            stat({2'h0, k[1] ? c & cascade_in : c, 1'b0, c, d_4}, 6'h0B);
            check(32'(local_out), 32'(c));
            check(32'(global_out), 32'(d_4));
         end
         ce <= 1'b0;
      end
      acc(1'b1, CLE_OFF_CFG, 32'h0000_0000, 32'h0000_0000, 1'b1);
      acc(1'b1, CLE_OFF_STAT, 32'h0000_0000, 32'h0000_0000, 1'b1);
      acc(1'b0, CLE_OFF_CFG, cv, 32'hFFFF_FFFF, 1'b0);
      cfg(cw(CLE_OP_ARITH, 3'h6, 8'h04), 32'h0000_E896);
      for (int i = 0; i < 8; i++) begin
         {w_carry, d_b, d_a} <= 3'(i);
         w_casc <= 1'($urandom());
         tick(3);
         c = ^3'(i);
         cy = (i[0] & i[1]) | (i[2] & (i[0] | i[1]));
         stat({2'h0, c & cascade_in, cy, c, 1'b0}, 6'h0E);
         check(32'(carry_out), 32'(cy));
         check(32'(cascade_out), 32'(c & cascade_in));
         check(32'(global_out), 32'(c));
      end
      for (int o = 2; o < 4; o++) begin
         lut = 16'($urandom());
         cfg(cw(2'(o), 3'h6, 8'h08), 32'(lut));
         for (int j = 0; j < 8; j++) begin
            {d_a, d_b, d_4, w_carry, w_casc} <= 5'($urandom()) | ((j == 0) ? 5'h04 : 5'h00);
            tick(2);
            ce <= 1'b1;
            tick(1);
            ce <= 1'b0;
            e3 = (o == 2) ? cascade_in : 1'b1;
            q = d_4 ? d_b : (d_a ? lut[{1'b0, e3, carry_in, q}] : q);
            if (o == 3 && !cascade_in) q = 1'b0;
            tick(2);
            stat({3'h0, lut[{1'b1, e3, carry_in, q}], 1'b0, q}, 6'h05);
            check(32'(carry_out), 32'(lut[{1'b1, e3, carry_in, q}]));
            check(32'(local_out), 32'(q));
         end
      end
      for (int m = 0; m < 6; m++) begin
         cfg(cw(CLE_OP_NORMAL, 3'(m), 8'h01), 32'h0000_0000);
         step(1'b1, 1'b0, 1'b0, 1'b0, eb[m]);
         step(1'b0, 1'b1, 1'b0, 1'b0, ec[m]);
         step(1'b1, 1'b0, 1'b1, 1'b0, (m == 0) ? 2'h0 : 2'h1);
      end
      // Preset through the inverted clear path: the register ends high although the load data is low.
      cfg(cw(CLE_OP_NORMAL, CLE_AC_PRESET, 8'h21), 32'h0000_0000);
      step(1'b1, 1'b0, 1'b0, 1'b0, 2'h1);
      for (int p = 0; p < 2; p++) begin
         cfg(cw(CLE_OP_NORMAL, CLE_AC_LOAD, 8'h41 | 8'(p << 7)), 32'h0000_0000);
         step(1'b1, 1'b0, !p[0], 1'b1, {1'b0, p[0]});
      end
      for (int i = 0; i < 10; i++) begin
         {bd, be} <= 8'($urandom());
         tick(2);
         c = ($countones(be) == 0) ? 1'b1 : ($countones(be) > 1) ? 1'b0 : |(bd & be);
         stat({1'b0, c, 4'h0}, 6'h10);
         check(32'(bus_out), 32'(c));
      end
      print_verdict();
   end
endmodule // testbench
